// >>> hw/boe_core.sv
`timescale 1ns/10ps
`default_nettype none
module boe_core (
	// Clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst_n,
	// Program memory
	output logic      [boe_pkg::PC_W-1:0]     prog_addr,
	input  wire logic [boe_pkg::WORD_W-1:0]   prog_word,
	// Data file
	output logic      [boe_pkg::ADDR_W-1:0]   file_raddr,
	input  wire logic [boe_pkg::DATA_W-1:0]   file_rdata,
	input  wire logic [boe_pkg::DATA_W-1:0]   pin_rdata,
	output logic                              file_we,
	output logic      [boe_pkg::ADDR_W-1:0]   file_waddr,
	output logic      [boe_pkg::DATA_W-1:0]   file_wdata,
	// Timer prescaler
	input  wire logic                         presc_assigned,
	output logic                              presc_clear,
	// Register port
	input  wire logic [boe_pkg::RADDR_W-1:0]  reg_addr,
	input  wire logic [boe_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [boe_pkg::DATA_W-1:0]   reg_rdata
);
	import boe_pkg::*;

	boe_alu_if alu_bus ();

	boe_alu u_alu (
		.bus (alu_bus.alu)
	);

	boe_state_t  state_r;
	logic [15:0] pc_r;
	logic [7:0]  acc_r;
	logic [4:0]  status_r;
	logic [3:0]  bank_r;
	logic [15:0] prod_r;
	logic [7:0]  move_data_r;
	logic        wb_we_r;
	logic [11:0] wb_addr_r;
	logic [7:0]  wb_data_r;
	logic        presc_clear_r;
	logic [7:0]  reg_rdata_r;

	logic [3:0]  opc;
	logic [1:0]  sub;
	logic        dbit;
	logic        abit;
	logic [7:0]  fld;
	boe_op_t     op;
	logic        wr_en;
	logic [4:0]  fl_mask;
	boe_skip_t   skip_kind;
	logic        is_mul;
	logic        is_move1;
	logic        is_brz;
	logic        execute;
	logic [11:0] eff_addr;
	logic        is_port;
	logic        rmw;
	logic [7:0]  operand;
	logic        skip_true;
	logic        brz_taken;
	logic [15:0] brz_target;
	logic        file_wr_now;
	logic        acc_wr_now;

	assign opc  = prog_word[15:12];
	assign sub  = prog_word[11:10];
	assign dbit = prog_word[9];
	assign abit = prog_word[8];
	assign fld  = prog_word[7:0];

	always_comb begin
		op        = ALU_PASS;
		wr_en     = 1'b0;
		fl_mask   = FL_NONE;
		skip_kind = SK_NONE;
		is_mul    = 1'b0;
		is_move1  = 1'b0;
		is_brz    = 1'b0;
		case (opc)
			OP_MISC: begin
				if (prog_word == DADJ_WORD) begin
					op      = ALU_DADJ;
					wr_en   = 1'b1;
					fl_mask = FL_C;
				end else if (prog_word[11:9] == MUL_SUB) begin
					is_mul = 1'b1;
				end else if (sub == 2'b01) begin
					op      = ALU_DEC;
					wr_en   = 1'b1;
					fl_mask = FL_ALL;
				end
			end
			OP_LOGIC: begin
				wr_en   = 1'b1;
				fl_mask = FL_ZN;
				case (sub)
					2'b00:   op = ALU_OR;
					2'b01:   op = ALU_AND;
					2'b10:   op = ALU_XOR;
					default: op = ALU_COM;
				endcase
			end
			OP_ADD: begin
				wr_en   = 1'b1;
				fl_mask = FL_ALL;
				case (sub)
					2'b00:   op = ALU_ADDC;
					2'b01:   op = ALU_ADD;
					2'b10:   op = ALU_INC;
					default: begin
						op        = ALU_DEC;
						fl_mask   = FL_NONE;
						skip_kind = SK_ZERO;
					end
				endcase
			end
			OP_ROT: begin
				case (sub)
					2'b00: begin
						op      = ALU_RRC;
						wr_en   = 1'b1;
						fl_mask = FL_CZN;
					end
					2'b01: begin
						op      = ALU_RLC;
						wr_en   = 1'b1;
						fl_mask = FL_CZN;
					end
					2'b11: begin
						op        = ALU_INC;
						wr_en     = 1'b1;
						skip_kind = SK_ZERO;
					end
					default: wr_en = 1'b0;
				endcase
			end
			OP_ROTN: begin
				wr_en = 1'b1;
				case (sub)
					2'b00: begin
						op      = ALU_RR;
						fl_mask = FL_ZN;
					end
					2'b01: begin
						op      = ALU_RL;
						fl_mask = FL_ZN;
					end
					2'b10: begin
						op        = ALU_INC;
						skip_kind = SK_NZ;
					end
					default: begin
						op        = ALU_DEC;
						skip_kind = SK_NZ;
					end
				endcase
			end
			OP_SUB: begin
				wr_en   = 1'b1;
				fl_mask = FL_ALL;
				case (sub)
					2'b11:   op = ALU_SUBF;
					2'b10:   op = ALU_SUBFB;
					2'b01:   op = ALU_SUBWB;
					default: fl_mask = FL_ZN;
				endcase
			end
			OP_CMP: begin
				case (prog_word[11:9])
					3'b000:  skip_kind = SK_LT;
					3'b001:  skip_kind = SK_EQ;
					3'b010:  skip_kind = SK_GT;
					default: skip_kind = SK_NONE;
				endcase
			end
			OP_MOVE1:  is_move1 = 1'b1;
			OP_BRANCH: is_brz = (prog_word[11:8] == BRZ_SUB);
			// A stray destination word lands here and does nothing
			default:   wr_en = 1'b0;
		endcase
	end

	// Access-bank addresses from ACC_SPLIT up reach the special registers without touching bank select
	always_comb begin
		if (abit)
			eff_addr = {bank_r, fld};
		else if (fld < ACC_SPLIT)
			eff_addr = {ACC_LO_BANK, fld};
		else
			eff_addr = {ACC_HI_BANK, fld};
	end

	assign execute    = (state_r == ST_EXEC);
	assign file_raddr = is_move1 ? prog_word[11:0] : eff_addr;
	assign is_port    = (file_raddr >= PORT_LO) && (file_raddr <= PORT_HI);
	assign rmw        = wr_en && dbit && !is_move1;

	// Pins win on a port rewrite; otherwise forward the pending write so no stale byte is read
	always_comb begin
		if (rmw && is_port)
			operand = pin_rdata;
		else if (wb_we_r && (wb_addr_r == file_raddr))
			operand = wb_data_r;
		else
			operand = file_rdata;
	end

	assign alu_bus.op       = op;
	assign alu_bus.acc      = acc_r;
	assign alu_bus.file_val = operand;
	assign alu_bus.c_in     = status_r[ST_C];
	assign alu_bus.hc_in    = status_r[ST_HC];

	always_comb begin
		case (skip_kind)
			SK_ZERO: skip_true = (alu_bus.result == 8'h00);
			SK_NZ:   skip_true = (alu_bus.result != 8'h00);
			SK_EQ:   skip_true = (operand == acc_r);
			SK_GT:   skip_true = (operand > acc_r);
			SK_LT:   skip_true = (operand < acc_r);
			default: skip_true = 1'b0;
		endcase
	end

	assign brz_taken   = is_brz && status_r[ST_Z];
	assign brz_target  = pc_r + PC_STEP + {{7{fld[7]}}, fld, 1'b0};
	assign file_wr_now = execute && wr_en && dbit;
	assign acc_wr_now  = execute && wr_en && !dbit;

	// Sequencer and program counter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_EXEC;
			pc_r    <= PC_RESET;
		end else begin
			case (state_r)
				ST_EXEC: begin
					if (is_move1) begin
						state_r <= ST_MOVE2;
						pc_r    <= pc_r + PC_STEP;
					end else if (brz_taken) begin
						state_r <= ST_STALL;
						pc_r    <= brz_target;
					end else if (skip_true) begin
						state_r <= ST_SKIP;
						pc_r    <= pc_r + PC_STEP;
					end else begin
						pc_r    <= pc_r + PC_STEP;
					end
				end
				ST_SKIP: begin
					state_r <= ST_EXEC;
					pc_r    <= pc_r + PC_STEP;
				end
				ST_MOVE2: begin
					state_r <= ST_EXEC;
					pc_r    <= pc_r + PC_STEP;
				end
				default: state_r <= ST_EXEC;
			endcase
		end
	end

	// Software writes win over the core in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			acc_r <= 8'h00;
		else if (reg_wr && (reg_addr == RA_ACC))
			acc_r <= reg_wdata;
		else if (acc_wr_now)
			acc_r <= alu_bus.result;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			status_r <= 5'h00;
		else if (reg_wr && (reg_addr == RA_STATUS))
			status_r <= reg_wdata[4:0];
		else if (execute)
			status_r <= (status_r & ~fl_mask) | (alu_bus.flags & fl_mask);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			bank_r <= 4'h0;
		else if (reg_wr && (reg_addr == RA_BANK))
			bank_r <= reg_wdata[3:0];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			prod_r <= 16'h0000;
		else if (execute && is_mul)
			prod_r <= alu_bus.product;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			move_data_r <= 8'h00;
		else if (execute && is_move1)
			move_data_r <= operand;
	end

	// File writes are registered one cycle; the forward path above hides the delay
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wb_we_r   <= 1'b0;
			wb_addr_r <= 12'h000;
			wb_data_r <= 8'h00;
		end else if (state_r == ST_MOVE2) begin
			wb_we_r   <= 1'b1;
			wb_addr_r <= prog_word[11:0];
			wb_data_r <= move_data_r;
		end else begin
			wb_we_r   <= file_wr_now;
			wb_addr_r <= file_raddr;
			wb_data_r <= alu_bus.result;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			presc_clear_r <= 1'b0;
		else
			presc_clear_r <= presc_assigned && ((file_wr_now && (file_raddr == TIMER_ADDR)) ||
				((state_r == ST_MOVE2) && (prog_word[11:0] == TIMER_ADDR)));
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			reg_rdata_r <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
				RA_ACC:    reg_rdata_r <= acc_r;
				RA_STATUS: reg_rdata_r <= {3'h0, status_r};
				RA_BANK:   reg_rdata_r <= {4'h0, bank_r};
				RA_PROD_LO: reg_rdata_r <= prod_r[7:0];
				RA_PROD_HI: reg_rdata_r <= prod_r[15:8];
				default:   reg_rdata_r <= 8'h00;
			endcase
		end else
			reg_rdata_r <= 8'h00;
	end

	assign prog_addr   = pc_r;
	assign file_we     = wb_we_r;
	assign file_waddr  = wb_addr_r;
	assign file_wdata  = wb_data_r;
	assign presc_clear = presc_clear_r;
	assign reg_rdata   = reg_rdata_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_move_first;
		execute && is_move1;
	endsequence

	sequence s_move_second;
		state_r == ST_MOVE2;
	endsequence

	chk_skip_quiet: assert property ((state_r == ST_SKIP) && !reg_wr |=>
		$stable(acc_r) && $stable(status_r) && !file_we)
		else $error("skipped word changed state");
	chk_stall_nop: assert property ((state_r == ST_STALL) && !reg_wr |=>
		$stable(acc_r) && $stable(status_r) && !file_we)
		else $error("stall cycle did work");
	chk_brz_taken: assert property (execute && brz_taken |=>
		(pc_r == $past(brz_target)) && (state_r == ST_STALL) ##1 (state_r == ST_EXEC))
		else $error("branch on zero wrong target or timing");
	chk_brz_fall: assert property (execute && is_brz && !status_r[ST_Z] |=>
		(pc_r == $past(pc_r) + PC_STEP) && (state_r == ST_EXEC))
		else $error("untaken branch misbehaved");
	chk_move_pair: assert property (s_move_first ##1 s_move_second |=>
		file_we && (file_wdata == $past(move_data_r)) && (state_r == ST_EXEC))
		else $error("two word move did not write destination");
	chk_move_enter: assert property (s_move_first |=> s_move_second)
		else $error("move did not take second word");
	chk_skip_flags: assert property (execute && (skip_kind != SK_NONE) && !reg_wr |=>
		$stable(status_r))
		else $error("skip form changed flags");
	chk_mul_product: assert property (execute && is_mul && !reg_wr |=>
		$stable(status_r) && (prod_r == $past(alu_bus.product)))
		else $error("multiply wrong or touched flags");
	chk_logic_flags: assert property (execute && (opc == OP_LOGIC) && !reg_wr |=>
		(status_r[ST_C] == $past(status_r[ST_C])) &&
		(status_r[ST_Z] == ($past(alu_bus.result) == 8'h00)))
		else $error("logic op flags wrong");
	chk_dec_file: assert property (execute && (opc == OP_MISC) && (sub == 2'b01) && dbit |=>
		file_we && (file_wdata == $past(operand) - 8'h01))
		else $error("decrement file wrong");
	chk_presc_clr: assert property (file_wr_now && (file_raddr == TIMER_ADDR) &&
		presc_assigned |=> presc_clear)
		else $error("prescaler not cleared");
	chk_port_pins: assert property (rmw && is_port |-> alu_bus.file_val == pin_rdata)
		else $error("port rewrite did not use pins");
endmodule : boe_core
`default_nettype wire

// >>> common/boe_pkg.sv
`default_nettype none
package boe_pkg;
	// Widths
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned ADDR_W  = 12;
	localparam int unsigned PC_W    = 16;
	localparam int unsigned WORD_W  = 16;
	localparam int unsigned RADDR_W = 3;

	// Opcode prefixes in word bits 15:12; BRZ_SUB matches bits 11:8, MUL_SUB bits 11:9, DADJ_WORD the whole word
	localparam logic [3:0] OP_MISC   = 4'h0;
	localparam logic [3:0] OP_LOGIC  = 4'h1;
	localparam logic [3:0] OP_ADD    = 4'h2;
	localparam logic [3:0] OP_ROT    = 4'h3;
	localparam logic [3:0] OP_ROTN   = 4'h4;
	localparam logic [3:0] OP_SUB    = 4'h5;
	localparam logic [3:0] OP_CMP    = 4'h6;
	localparam logic [3:0] OP_MOVE1  = 4'hc;
	localparam logic [3:0] OP_BRANCH = 4'he;
	localparam logic [3:0] BRZ_SUB   = 4'h0;
	localparam logic [2:0] MUL_SUB   = 3'h1;
	localparam logic [15:0] DADJ_WORD = 16'h0007;

	// Status bit positions; flag masks use the same order
	localparam int unsigned ST_C  = 0;
	localparam int unsigned ST_HC = 1;
	localparam int unsigned ST_Z  = 2;
	localparam int unsigned ST_SV = 3;
	localparam int unsigned ST_N  = 4;
	localparam logic [4:0] FL_NONE = 5'h00;
	localparam logic [4:0] FL_C    = 5'h01;
	localparam logic [4:0] FL_ZN   = 5'h14;
	localparam logic [4:0] FL_CZN  = 5'h15;
	localparam logic [4:0] FL_ALL  = 5'h1f;

	// Address map, program counter step and reset, decimal adjust nibble limit and fix
	localparam logic [7:0]  ACC_SPLIT   = 8'h60;
	localparam logic [3:0]  ACC_LO_BANK = 4'h0;
	localparam logic [3:0]  ACC_HI_BANK = 4'hf;
	localparam logic [11:0] PORT_LO     = 12'hf80;
	localparam logic [11:0] PORT_HI     = 12'hf84;
	localparam logic [11:0] TIMER_ADDR  = 12'hfd6;
	localparam logic [15:0] PC_STEP     = 16'h0002;
	localparam logic [15:0] PC_RESET    = 16'h0000;
	localparam logic [3:0]  NIB_MAX     = 4'h9;
	localparam logic [3:0]  BCD_FIX     = 4'h6;

	// Register port map
	localparam logic [2:0] RA_ACC     = 3'h0;
	localparam logic [2:0] RA_STATUS  = 3'h1;
	localparam logic [2:0] RA_BANK    = 3'h2;
	localparam logic [2:0] RA_PROD_LO = 3'h3;
	localparam logic [2:0] RA_PROD_HI = 3'h4;

	typedef enum logic [4:0] {
		ALU_PASS = 5'b00000, ALU_ADD = 5'b00001, ALU_ADDC = 5'b00010, ALU_AND = 5'b00011,
		ALU_OR = 5'b00100, ALU_XOR = 5'b00101, ALU_COM = 5'b00110, ALU_RLC = 5'b00111,
		ALU_RRC = 5'b01000, ALU_RL = 5'b01001, ALU_RR = 5'b01010, ALU_SUBF = 5'b01011,
		ALU_SUBFB = 5'b01100, ALU_SUBWB = 5'b01101, ALU_INC = 5'b01110, ALU_DEC = 5'b01111,
		ALU_DADJ = 5'b10000
	} boe_op_t;

	typedef enum logic [1:0] {
		ST_EXEC = 2'b00, ST_SKIP = 2'b01, ST_STALL = 2'b10, ST_MOVE2 = 2'b11
	} boe_state_t;

	typedef enum logic [2:0] {
		SK_NONE = 3'b000, SK_ZERO = 3'b001, SK_NZ = 3'b010,
		SK_EQ = 3'b011, SK_GT = 3'b100, SK_LT = 3'b101
	} boe_skip_t;
endpackage : boe_pkg
`default_nettype wire

// >>> common/boe_alu_if.sv
`timescale 1ns/10ps
`default_nettype none
interface boe_alu_if;
	import boe_pkg::*;
	boe_op_t     op;
	logic [7:0]  acc;
	logic [7:0]  file_val;
	logic        c_in;
	logic        hc_in;
	logic [7:0]  result;
	logic [4:0]  flags;
	logic [15:0] product;
	modport core (output op, acc, file_val, c_in, hc_in, input result, flags, product);
	modport alu  (input op, acc, file_val, c_in, hc_in, output result, flags, product);
endinterface : boe_alu_if
`default_nettype wire

// >>> hw/boe_alu.sv
`timescale 1ns/10ps
`default_nettype none
module boe_alu (
	// Operands and results
	boe_alu_if.alu bus
);
	import boe_pkg::*;

	logic [7:0] x;
	logic [7:0] y;
	logic       cin;
	logic [8:0] sum;
	logic [4:0] lo;
	logic       lo_fix;
	logic       hi_fix;
	logic [8:0] bcd;
	logic [4:0] bcd_hi;
	logic [7:0] res;
	logic       c;

	// Every add and subtract shares one adder; subtraction adds the inverse
	always_comb begin
		x   = bus.file_val;
		y   = bus.acc;
		cin = 1'b0;
		case (bus.op)
			ALU_ADDC:  cin = bus.c_in;
			ALU_SUBF: begin
				y   = ~bus.acc;
				cin = 1'b1;
			end
			ALU_SUBFB: begin
				y   = ~bus.acc;
				cin = bus.c_in;
			end
			ALU_SUBWB: begin
				x   = bus.acc;
				y   = ~bus.file_val;
				cin = bus.c_in;
			end
			ALU_INC: begin
				y   = 8'h00;
				cin = 1'b1;
			end
			ALU_DEC:   y = 8'hff;
			default:   cin = 1'b0;
		endcase
		sum = {1'b0, x} + {1'b0, y} + {8'h00, cin};
		lo  = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
	end

	// Low nibble fixed first so its carry reaches the high nibble test
	always_comb begin
		lo_fix = (bus.acc[3:0] > NIB_MAX) | bus.hc_in;
		bcd    = {1'b0, bus.acc} + {5'h00, (lo_fix ? BCD_FIX : 4'h0)};
		hi_fix = (bcd[7:4] > NIB_MAX) | bus.c_in | bcd[8];
		bcd_hi = {1'b0, bcd[7:4]} + {1'b0, (hi_fix ? BCD_FIX : 4'h0)};
	end

	always_comb begin
		res = sum[7:0];
		c   = sum[8];
		case (bus.op)
			ALU_AND:  res = bus.acc & bus.file_val;
			ALU_OR:   res = bus.acc | bus.file_val;
			ALU_XOR:  res = bus.acc ^ bus.file_val;
			ALU_COM:  res = ~bus.file_val;
			ALU_RLC: begin
				res = {bus.file_val[6:0], bus.c_in};
				c   = bus.file_val[7];
			end
			ALU_RRC: begin
				res = {bus.c_in, bus.file_val[7:1]};
				c   = bus.file_val[0];
			end
			ALU_RL:   res = {bus.file_val[6:0], bus.file_val[7]};
			ALU_RR:   res = {bus.file_val[0], bus.file_val[7:1]};
			ALU_PASS: res = bus.file_val;
			ALU_DADJ: begin
				res = {bcd_hi[3:0], bcd[3:0]};
				c   = bus.c_in | bcd[8] | bcd_hi[4];
			end
			default:  res = sum[7:0];
		endcase
	end

	assign bus.result        = res;
	assign bus.flags[ST_C]   = c;
	assign bus.flags[ST_HC]  = lo[4];
	assign bus.flags[ST_Z]   = (res == 8'h00);
	assign bus.flags[ST_SV]  = (x[7] == y[7]) && (sum[7] != x[7]);
	assign bus.flags[ST_N]   = res[7];
	assign bus.product       = {8'h00, bus.acc} * {8'h00, bus.file_val};
endmodule : boe_alu
`default_nettype wire

// >>> sim/boe_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module boe_mem_model (
	// Clock
	input  wire logic        clock,
	// Program side
	input  wire logic [15:0] prog_addr,
	output logic      [15:0] prog_word,
	// Data file side
	input  wire logic [11:0] file_raddr,
	output logic      [7:0]  file_rdata,
	output logic      [7:0]  pin_rdata,
	input  wire logic        file_we,
	input  wire logic [11:0] file_waddr,
	input  wire logic [7:0]  file_wdata
);
	logic [15:0] prog [256];
	logic [7:0]  dmem [4096];

	// Word-wide store, so the byte address drops its low bit
	assign prog_word  = prog[prog_addr[8:1]];
	assign file_rdata = dmem[file_raddr];
	// Pins read opposite to the latch, so a latch-sourced operand is caught
	assign pin_rdata  = ~dmem[file_raddr];

	always @(posedge clock) begin
		if (file_we) begin
			dmem[file_waddr] <= file_wdata;
		end
	end
endmodule : boe_mem_model
`default_nettype wire

// >>> sim/byte_op_instruction_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
module byte_op_instruction_exec_tb;
	import boe_pkg::*;
	logic        clock;
	logic        rst_n = 1'h0;
	logic [15:0] prog_addr;
	logic [15:0] prog_word;
	logic [11:0] file_raddr;
	logic [7:0]  file_rdata;
	logic [7:0]  pin_rdata;
	logic        file_we;
	logic [11:0] file_waddr;
	logic [7:0]  file_wdata;
	logic        presc_assigned = 1'h1;
	logic        presc_clear;
	logic [2:0]  reg_addr = 3'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic [7:0]  reg_rdata;
	int          fails = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          presc_seen;
	int          we_seen;
	// Rows: opcode byte, acc, file, status in, acc out, status out, file out
	logic [55:0] arith [20] = '{
		56'h24_7f_01_00_80_1a_01, 56'h20_ff_00_01_00_07_00, 56'h14_f0_8f_0b_80_1b_8f,
		56'h10_00_00_13_00_07_00, 56'h18_55_55_08_00_0c_55, 56'h1c_00_0f_00_f0_10_0f,
		56'h34_00_41_09_83_18_41, 56'h30_00_01_00_00_05_01, 56'h44_00_80_01_01_01_80,
		56'h40_00_01_00_80_10_01, 56'h5c_01_10_00_0f_01_10, 56'h58_00_00_00_ff_10_00,
		56'h54_80_01_01_7f_09_01, 56'h04_00_01_00_00_07_01, 56'h06_33_01_00_33_07_00,
		56'h00_a5_00_00_05_01_00, 56'h02_10_20_1f_10_1f_20, 56'h28_55_ff_00_00_07_ff,
		56'h50_00_80_01_80_11_80, 56'h38_12_34_1f_12_1f_34};
	// Rows: opcode byte, file, acc, file out; every row makes its skip true
	logic [31:0] skips [7] = '{32'h3e_ff_00_00, 32'h4a_00_00_01, 32'h2e_01_00_00,
		32'h4e_05_00_04, 32'h62_40_40_40, 32'h64_41_40_41, 32'h60_3f_40_3f};

	boe_core u_dut (.clock, .rst_n, .prog_addr, .prog_word, .file_raddr, .file_rdata,
		.pin_rdata, .file_we, .file_waddr, .file_wdata, .presc_assigned, .presc_clear,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	boe_mem_model u_mem (.clock, .prog_addr, .prog_word, .file_raddr, .file_rdata,
		.pin_rdata, .file_we, .file_waddr, .file_wdata);

	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end

	task automatic close_out();
		$display("compares %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	// Generous ceiling; the whole run needs about 1560 cycles
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (presc_clear === 1'h1) presc_seen++;
		if (file_we === 1'h1) we_seen++;
		if (cyc == 8000) begin
			fails++;
			close_out();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'h0;
		#1 v = reg_rdata;
	endtask : rd

	// Program sits at word 10, leaving idle words for register setup
	task automatic start(input logic [15:0] w [6], input logic [11:0] fa, input logic [7:0] fv);
		@(posedge clock);
		rst_n <= 1'h0;
		for (int i = 0; i < 256; i++) u_mem.prog[i] = 16'h0;
		for (int i = 0; i < 4096; i++) u_mem.dmem[i] = 8'h00;
		for (int i = 0; i < 6; i++) u_mem.prog[10 + i] = w[i];
		u_mem.dmem[fa] = fv;
		presc_seen = 0;
		we_seen = 0;
		repeat (12) @(posedge clock);
		rst_n <= 1'h1;
	endtask : start

	task automatic t_arith();
		logic [55:0] r;
		logic [7:0]  v;
		logic [7:0]  v2;
		for (int i = 0; i < 20; i++) begin
			r = arith[i];
			start('{{r[55:48], 8'h07}, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0}, 12'h007, r[39:32]);
			wr(RA_ACC, r[47:40]);
			wr(RA_STATUS, r[31:24]);
			repeat (30) @(posedge clock);
			rd(RA_ACC, v);
			check("acc", v, r[23:16]);
			rd(RA_STATUS, v);
			check("status", v, r[15:8]);
			check("file", u_mem.dmem[7], r[7:0]);
			if (r[55:48] == 8'h02) begin
				rd(RA_PROD_LO, v);
				rd(RA_PROD_HI, v2);
				check("product", {v2, v}, 16'h0200);
			end
		end
		$display("arith table done");
	endtask : t_arith

	task automatic t_skip();
		logic [31:0] r;
		logic [7:0]  v;
		for (int i = 0; i < 7; i++) begin
			r = skips[i];
			start('{{r[31:24], 8'h20}, 16'h0621, 16'h0, 16'h0, 16'h0, 16'h0}, 12'h020, r[23:16]);
			wr(RA_ACC, r[15:8]);
			wr(RA_STATUS, 8'h15);
			repeat (30) @(posedge clock);
			check("skip file", u_mem.dmem[12'h020], r[7:0]);
			check("skipped", u_mem.dmem[12'h021], 8'h00);
			rd(RA_STATUS, v);
			check("skip status", v, 8'h15);
		end
		$display("skip table done");
	endtask : t_skip

	task automatic t_branch();
		for (int z = 0; z < 2; z++) begin
			start('{16'he003, 16'h0601, 16'h0601, 16'h0601, 16'h0602, 16'h0}, 12'h000, 8'h00);
			wr(RA_STATUS, z ? 8'h04 : 8'h00);
			repeat (30) @(posedge clock);
			check("fall path", u_mem.dmem[1], z ? 8'h00 : 8'hfd);
			check("target", u_mem.dmem[2], 8'hff);
		end
		$display("branch done");
	endtask : t_branch

	task automatic t_addr();
		logic [7:0] v;
		// Second pass hands the prescaler elsewhere, so the timer write must not clear it
		for (int p = 1; p >= 0; p--) begin
			start('{16'h0710, 16'h0680, 16'hc005, 16'hf030, 16'h06d6, 16'hf031}, 12'h005, 8'h5a);
			presc_assigned <= p[0];
			rd(RA_ACC, v);
			check("reset acc", v, 8'h00);
			wr(RA_BANK, 8'h02);
			rd(3'h5, v);
			check("unmapped", v, 8'h00);
			repeat (30) @(posedge clock);
			check("banked", u_mem.dmem[12'h210], 8'hff);
			check("port", u_mem.dmem[12'hf80], 8'hfe);
			check("move", u_mem.dmem[12'h030], 8'h5a);
			check("lone word", u_mem.dmem[12'h031], 8'h00);
			check("timer", u_mem.dmem[12'hfd6], 8'hff);
			check("prescaler", presc_seen, p);
			check("writes", we_seen, 4);
		end
		$display("addressing done");
	endtask : t_addr

	initial begin
		t_addr();
		t_arith();
		t_skip();
		t_branch();
		close_out();
	end
endmodule : byte_op_instruction_exec_tb
`default_nettype wire
